// ---- rtl/clk_sys_pkg.sv ----
// constants, types and helper functions shared by the system clock controller
package clk_sys_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [11:0] OSC_CONTROL_OFF   = 12'h000;
	localparam logic [11:0] CLOCK_DIVISOR_OFF = 12'h004;
	localparam logic [11:0] PLL_FEEDBACK_OFF  = 12'h008;

	localparam logic [15:0] CLOCK_DIVISOR_RST  = 16'h0040;
	localparam logic [15:0] CLOCK_DIVISOR_MASK = 16'h07df;
	localparam logic [8:0]  PLL_FEEDBACK_RST   = 9'h030;

	// field positions
	localparam int FRC_POST_LSB = 8;
	localparam int PLL_POST_LSB = 6;
	localparam int PLL_PRE_LSB  = 0;
	localparam int MODE_LSB     = 16;
	localparam int CUR_SRC_LSB  = 12;
	localparam int POR_SRC_LSB  = 8;
	localparam int PLL_ACT_BIT  = 5;
	localparam int FAIL_BIT     = 3;

	// ****************************************
	// timing and arithmetic constants
	// ****************************************
	localparam int          LOW_POWER_RC_OSC_FREQ_HZ    = 32768;
	localparam int          PCLK_FREQ_HZ    = 100000000;
	localparam logic [1:0]  SYNC_SETTLE     = 2'h2;
	localparam logic [3:0]  FAIL_LOW_POWER_RC_OSC_TICKS = 4'h2;
	localparam logic [9:0]  PLL_PRE_BASE    = 10'h002;
	localparam logic [9:0]  PLL_FB_BASE     = 10'h002;
	localparam logic [8:0]  FRC_DIV16_RATIO = 9'h010;
	localparam logic [11:0] CREDIT_MAX      = 12'hfff;
	localparam logic [3:0]  MODE_INVALID    = 4'hf;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {
		SRC_FRC       = 3'b000,
		SRC_FRC_PLL   = 3'b001,
		SRC_PRI       = 3'b010,
		SRC_PRI_PLL   = 3'b011,
		SRC_SEC       = 3'b100,
		SRC_LOW_POWER_RC_OSC      = 3'b101,
		SRC_FRC_DIV16 = 3'b110,
		SRC_FRC_POST  = 3'b111
	} src_t;

	typedef enum logic [1:0] {
		KIND_EXT    = 2'b00,
		KIND_XTAL   = 2'b01,
		KIND_HSXTAL = 2'b10
	} kind_t;

	typedef enum logic [1:0] {
		PH_SYNC = 2'b00,
		PH_LOAD = 2'b01,
		PH_RUN  = 2'b10
	} phase_t;

	// fast rc postscale code to divide ratio
	function automatic logic [8:0] frc_ratio(input logic [2:0] sel);
		frc_ratio = (sel == 3'h7) ? 9'h100 : (9'h001 << sel);
	endfunction

	// pll postscale code to divide ratio; reserved code runs as divide by 4
	function automatic logic [3:0] post_ratio(input logic [1:0] sel);
		unique case (sel)
			2'b00:   post_ratio = 4'h2;
			2'b11:   post_ratio = 4'h8;
			default: post_ratio = 4'h4;
		endcase
	endfunction

	// twelve clock modes from source code and primary kind
	function automatic logic [3:0] mode_index(input src_t src, input logic [1:0] kind);
		logic [3:0] base;
		base = 4'h0;
		unique case (src)
			SRC_FRC:       mode_index = 4'h0;
			SRC_FRC_PLL:   mode_index = 4'h1;
			SRC_PRI:       base = 4'h2;
			SRC_PRI_PLL:   base = 4'h5;
			SRC_SEC:       mode_index = 4'h8;
			SRC_LOW_POWER_RC_OSC:      mode_index = 4'h9;
			SRC_FRC_DIV16: mode_index = 4'ha;
			SRC_FRC_POST:  mode_index = 4'hb;
		endcase
		if (src == SRC_PRI || src == SRC_PRI_PLL)
			mode_index = (kind == 2'b11) ? MODE_INVALID : base + {2'b00, kind};
	endfunction

endpackage

// ---- rtl/tick_divider.sv ----
// divides a stream of one-cycle ticks by a programmable ratio
`timescale 1ns/100ps
module tick_divider
	import clk_sys_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       tick,
	input  wire logic [8:0] ratio,
	output logic            out_tick
);

	typedef struct packed {
		logic [8:0] cnt;
		logic       out;
	} div_state_t;

	div_state_t q;
	div_state_t d;

	always_comb begin
		d = q;
		d.out = 1'b0;
		if (tick) begin
			// a ratio change does not restart the count: the running count is compared with the new limit
			if (q.cnt + 9'h001 >= ratio) begin
				d.cnt = 9'h000;
				d.out = 1'b1;
			end else begin
				d.cnt = q.cnt + 9'h001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			q <= '0;
		else
			q <= d;
	end

	assign out_tick = q.out;

endmodule

// ---- rtl/clk_sys_ctrl.sv ----
// system clock source selection, postscalers, pll model and clock fail monitor
`timescale 1ns/100ps

module clk_sys_ctrl
	import clk_sys_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        fast_rc_osc,
	input  wire logic        primary_osc_pin,
	input  wire logic        secondary_osc,
	input  wire logic        low_power_rc_osc,
	input  wire logic [2:0]  initial_source_sel,
	input  wire logic [1:0]  primary_osc_kind,
	input  wire logic        config_programmed,
	output logic             instr_clk,
	output logic             fosc_pulse,
	output logic             low_power_rc_osc_ref_pulse,
	output logic             clock_fail,
	output logic             osc_drive_en,
	output logic      [2:0]  current_source
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		phase_t      phase;
		logic [1:0]  wait_cnt;
		logic [9:0]  s1;
		logic [9:0]  s2;
		logic [3:0]  prev;
		src_t        por_src;
		logic [1:0]  kind;
		src_t        pend_src;
		src_t        act_src;
		logic [15:0] clock_divisor_reg;
		logic [8:0]  fbd;
		logic [2:0]  frc_sel;
		logic [4:0]  pre;
		logic [1:0]  post;
		logic [8:0]  fb;
		logic [11:0] credit;
		logic        fosc;
		logic        icl;
		logic        low_power_rc_osc_ref;
		logic        fail;
		logic [3:0]  fail_cnt;
		logic        drive_en;
		logic [31:0] rdata;
		logic        rdy;
		logic        err;
	} state_t;

	state_t q;
	state_t d;

	logic frc_post_tick;
	logic [3:0] osc_tick;
	logic [8:0] frc_div_ratio;

	// ticks from the synchronised oscillator pins: 0 fast rc, 1 primary, 2 secondary, 3 low-power rc
	assign osc_tick = q.s2[3:0] & ~q.prev;

	assign frc_div_ratio = (q.act_src == SRC_FRC_DIV16) ? FRC_DIV16_RATIO : frc_ratio(q.frc_sel);

	tick_divider u_frc_div (
		.pclk     (pclk),
		.presetn  (presetn),
		.tick     (osc_tick[0]),
		.ratio    (frc_div_ratio),
		.out_tick (frc_post_tick)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic        pll_on;
		logic        pll_in;
		logic        emit;
		logic        src_tick;
		logic        raw_tick;
		logic [9:0]  m_fac;
		logic [9:0]  n_fac;
		logic [12:0] sum;
		logic        setup;
		logic        wr;
		logic        hit;
		logic [31:0] rd;
		logic [2:0]  cfg_src;
		logic        use_pri;

		d = q;
		pll_on = 1'b0;
		pll_in = 1'b0;
		emit = 1'b0;
		src_tick = 1'b0;
		raw_tick = 1'b0;
		m_fac = 10'h000;
		n_fac = 10'h000;
		sum = 13'h0000;
		setup = 1'b0;
		wr = 1'b0;
		hit = 1'b0;
		rd = 32'h0000_0000;
		cfg_src = 3'h0;
		use_pri = 1'b0;

		// pins pass two flip-flops; stage two and a one-cycle-delayed copy of its oscillator bits are looked at
		d.s1 = {config_programmed, primary_osc_kind, initial_source_sel,
			low_power_rc_osc, secondary_osc, primary_osc_pin, fast_rc_osc};
		d.s2 = q.s1;
		d.prev = q.s2[3:0];

		// ****************************************
		// power-on source selection
		// ****************************************
		unique case (q.phase)
			PH_SYNC: begin
				d.wait_cnt = q.wait_cnt + 2'h1;
				if (q.wait_cnt == SYNC_SETTLE)
					d.phase = PH_LOAD;
			end
			PH_LOAD: begin
				cfg_src = q.s2[6:4];
				d.kind = q.s2[8:7];
				// unprogrammed falls back to fast rc
				if (!q.s2[9])
					cfg_src = SRC_FRC;
				// primary with an undefined kind is not a mode
				use_pri = (cfg_src == SRC_PRI) || (cfg_src == SRC_PRI_PLL);
				if (use_pri && q.s2[8:7] == 2'b11) begin
					cfg_src = SRC_FRC;
					use_pri = 1'b0;
				end
				d.por_src = src_t'(cfg_src);
				d.pend_src = src_t'(cfg_src);
				d.act_src = src_t'(cfg_src);
				// external clock needs no crystal drive
				d.drive_en = use_pri && (q.s2[8:7] == KIND_XTAL || q.s2[8:7] == KIND_HSXTAL);
				d.phase = PH_RUN;
			end
			PH_RUN: begin
			end
		endcase

		// ****************************************
		// pll model
		// ****************************************
		pll_on = (q.act_src == SRC_FRC_PLL) || (q.act_src == SRC_PRI_PLL);
		// pll input only from primary or fast rc
		pll_in = (q.act_src == SRC_PRI_PLL) ? osc_tick[1] : osc_tick[0];
		// prescale factor is field plus two
		n_fac = {5'h00, q.pre} + PLL_PRE_BASE;
		n_fac = 10'((n_fac * {6'h00, post_ratio(q.post)}));
		// feedback factor is field plus two
		m_fac = {1'b0, q.fb} + PLL_FB_BASE;
		// each input edge earns m credits, each output edge spends n1*n2
		// output edges come at most one per pclk, so the model is bursty and
		// saturates above the pclk rate
		emit = pll_on && (q.credit >= {2'h0, n_fac});
		sum = {1'b0, q.credit} + (pll_in ? {3'h0, m_fac} : 13'h0000);
		if (emit)
			sum = sum - {3'h0, n_fac};
		d.credit = (sum > {1'b0, CREDIT_MAX}) ? CREDIT_MAX : sum[11:0];
		if (!pll_on)
			d.credit = 12'h000;

		// ****************************************
		// system clock and instruction clock
		// ****************************************
		unique case (q.act_src)
			SRC_FRC:       src_tick = osc_tick[0];
			SRC_FRC_PLL:   src_tick = emit;
			SRC_PRI:       src_tick = osc_tick[1];
			SRC_PRI_PLL:   src_tick = emit;
			SRC_SEC:       src_tick = osc_tick[2];
			SRC_LOW_POWER_RC_OSC:      src_tick = osc_tick[3];
			SRC_FRC_DIV16: src_tick = frc_post_tick;
			SRC_FRC_POST:  src_tick = frc_post_tick;
		endcase
		if (q.phase != PH_RUN)
			src_tick = 1'b0;
		d.fosc = src_tick;
		// instruction clock toggles once per oscillator cycle
		if (src_tick)
			d.icl = ~q.icl;

		// changes while the clock is low and between edges, or at once after a failure with a switch pending
		// a dead source may freeze the instruction clock high, so the
		// fail-safe switch cannot wait for a low phase; a stopped clock
		// has no phase left to cut short
		if (q.phase == PH_RUN && !src_tick &&
			(!q.icl || (q.fail && q.act_src != q.pend_src))) begin
			if (q.act_src != q.pend_src)
				d.credit = 12'h000;
			d.act_src = q.pend_src;
			d.frc_sel = q.clock_divisor_reg[FRC_POST_LSB +: 3];
			d.pre = q.clock_divisor_reg[PLL_PRE_LSB +: 5];
			d.post = q.clock_divisor_reg[PLL_POST_LSB +: 2];
			d.fb = q.fbd;
		end

		d.low_power_rc_osc_ref = osc_tick[3];

		// ****************************************
		// clock fail monitor
		// ****************************************
		unique case (q.act_src)
			SRC_FRC, SRC_FRC_PLL, SRC_FRC_DIV16, SRC_FRC_POST: raw_tick = osc_tick[0];
			SRC_PRI, SRC_PRI_PLL: raw_tick = osc_tick[1];
			SRC_SEC:              raw_tick = osc_tick[2];
			SRC_LOW_POWER_RC_OSC:             raw_tick = osc_tick[3];
		endcase
		// no source edge across the reference ticks is a failure
		if (q.phase == PH_RUN && q.act_src != SRC_LOW_POWER_RC_OSC) begin
			if (raw_tick)
				d.fail_cnt = 4'h0;
			else if (osc_tick[3] && q.fail_cnt != FAIL_LOW_POWER_RC_OSC_TICKS)
				d.fail_cnt = q.fail_cnt + 4'h1;
		end else begin
			d.fail_cnt = 4'h0;
		end

		// ****************************************
		// apb slave
		// ****************************************
		setup = psel && !penable;
		wr = psel && penable && pwrite && q.rdy && !q.err;
		hit = (paddr == OSC_CONTROL_OFF) || (paddr == CLOCK_DIVISOR_OFF) || (paddr == PLL_FEEDBACK_OFF);
		rd[MODE_LSB +: 4] = mode_index(q.act_src, q.kind);
		rd[CUR_SRC_LSB +: 3] = q.act_src;
		rd[POR_SRC_LSB +: 3] = q.por_src;
		rd[PLL_ACT_BIT] = pll_on;
		rd[FAIL_BIT] = q.fail;
		d.rdy = setup;
		d.err = setup && !hit;
		if (setup) begin
			unique case (paddr)
				OSC_CONTROL_OFF:   d.rdata = rd;
				CLOCK_DIVISOR_OFF: d.rdata = {16'h0000, q.clock_divisor_reg};
				PLL_FEEDBACK_OFF:  d.rdata = {23'h000000, q.fbd};
				default:           d.rdata = 32'h0000_0000;
			endcase
		end

		if (wr) begin
			unique case (paddr)
				// postscale fields writable; bit 5 and bits 11 to 15 read as zero
				CLOCK_DIVISOR_OFF: d.clock_divisor_reg = pwdata[15:0] & CLOCK_DIVISOR_MASK;
				PLL_FEEDBACK_OFF:  d.fbd = pwdata[8:0];
				OSC_CONTROL_OFF:   if (pwdata[FAIL_BIT]) d.fail = 1'b0;
				default:           d.fbd = q.fbd;
			endcase
		end

		// set wins over a clear; fall back to fast rc
		if (q.phase == PH_RUN && q.act_src != SRC_LOW_POWER_RC_OSC && !raw_tick &&
			osc_tick[3] && q.fail_cnt + 4'h1 == FAIL_LOW_POWER_RC_OSC_TICKS) begin
			d.fail = 1'b1;
			d.pend_src = SRC_FRC;
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.clock_divisor_reg <= CLOCK_DIVISOR_RST;
			q.fbd <= PLL_FEEDBACK_RST;
			q.post <= CLOCK_DIVISOR_RST[PLL_POST_LSB +: 2];
			q.fb <= PLL_FEEDBACK_RST;
		end else begin
			q <= d;
		end
	end

	assign prdata = q.rdata;
	assign pready = q.rdy;
	assign pslverr = q.err;
	assign instr_clk = q.icl;
	assign fosc_pulse = q.fosc;
	assign low_power_rc_osc_ref_pulse = q.low_power_rc_osc_ref;
	assign clock_fail = q.fail;
	assign osc_drive_en = q.drive_en;
	assign current_source = q.act_src;

endmodule

// ---- tb/osc_model.sv ----
// oscillator sources that feed the clock controller
`timescale 1ns/100ps
module osc_model #(
	parameter int FRC_NS  = 80,
	parameter int PRI_NS  = 100,
	parameter int SEC_NS  = 160,
	parameter int LOW_POWER_RC_OSC_NS = 2000
) (
	input  wire logic	pri_en,
	output logic		fast_rc_osc,
	output logic		primary_osc_pin,
	output logic		secondary_osc,
	output logic		low_power_rc_osc
);
	// odd start offsets keep the sources out of phase with pclk
	initial begin
		fast_rc_osc = 1'b0;
		#3.3 forever #(FRC_NS / 2) fast_rc_osc = ~fast_rc_osc;
	end
	// external clock pin
	// a dead primary stands low rather than holding a stale level
	initial begin
		primary_osc_pin = 1'b0;
		#7.1 forever #(PRI_NS / 2) primary_osc_pin = pri_en & ~primary_osc_pin;
	end
	initial begin
		secondary_osc = 1'b0;
		#1.7 forever #(SEC_NS / 2) secondary_osc = ~secondary_osc;
	end
	initial begin
		low_power_rc_osc = 1'b0;
		#4.9 forever #(LOW_POWER_RC_OSC_NS / 2) low_power_rc_osc = ~low_power_rc_osc;
	end
endmodule

// ---- tb/clk_sys_ctrl_props.sv ----
// assertions on the system clock controller ports
`timescale 1ns/100ps
module clk_sys_ctrl_props
	import clk_sys_pkg::*;
(
	input wire logic	pclk,
	input wire logic	presetn,
	input wire logic	psel,
	input wire logic	penable,
	input wire logic	pwrite,
	input wire logic [11:0]	paddr,
	input wire logic [31:0]	pwdata,
	input wire logic	pready,
	input wire logic	pslverr,
	input wire logic	low_power_rc_osc,
	input wire logic [2:0]	initial_source_sel,
	input wire logic [1:0]	primary_osc_kind,
	input wire logic	config_programmed,
	input wire logic	instr_clk,
	input wire logic	fosc_pulse,
	input wire logic	low_power_rc_osc_ref_pulse,
	input wire logic	clock_fail,
	input wire logic	osc_drive_en,
	input wire logic [2:0]	current_source
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_answer; psel && !penable |=> pready ##1 !pready; endproperty
	a_answer: assert property (p_answer) else $error("access answer not one cycle");
	property p_unmapped; psel && !penable && paddr > 12'h008 |=> pready && pslverr; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	property p_toggle; fosc_pulse |-> $changed(instr_clk); endproperty
	a_toggle: assert property (p_toggle) else $error("instr clock missed a tick");
	property p_steady; !fosc_pulse |-> $stable(instr_clk); endproperty
	a_steady: assert property (p_steady) else $error("instr clock moved without tick");
	// switching while instr_clk is high would cut its high phase short
	property p_clean_switch; $changed(current_source) |-> !$past(instr_clk) || clock_fail; endproperty
	a_clean_switch: assert property (p_clean_switch) else $error("source switched mid phase");
	property p_fail_safe; $rose(clock_fail) |-> ##[0:2] current_source == 3'b000; endproperty
	a_fail_safe: assert property (p_fail_safe) else $error("no fallback after fail");
	property p_sticky;
		clock_fail && !(psel && penable && pwrite && paddr == OSC_CONTROL_OFF && pwdata[3]) |=> clock_fail;
	endproperty
	a_sticky: assert property (p_sticky) else $error("fail flag dropped by itself");
	property p_ref; $rose(low_power_rc_osc) |-> ##[1:4] low_power_rc_osc_ref_pulse ##1 !low_power_rc_osc_ref_pulse; endproperty
	a_ref: assert property (p_ref) else $error("reference pulse missing");
	property p_unprog; $rose(presetn) && !config_programmed |-> ##[4:8] current_source == 3'b000; endproperty
	a_unprog: assert property (p_unprog) else $error("unprogrammed start not fast rc");
	property p_drive;
		$rose(presetn) && config_programmed && initial_source_sel[2:1] == 2'b01
			&& primary_osc_kind inside {2'b01, 2'b10} |-> ##[4:8] osc_drive_en;
	endproperty
	a_drive: assert property (p_drive) else $error("crystal drive not enabled");
endmodule
bind clk_sys_ctrl clk_sys_ctrl_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .low_power_rc_osc(low_power_rc_osc), .initial_source_sel(initial_source_sel),
	.primary_osc_kind(primary_osc_kind), .config_programmed(config_programmed), .instr_clk(instr_clk),
	.fosc_pulse(fosc_pulse), .low_power_rc_osc_ref_pulse(low_power_rc_osc_ref_pulse), .clock_fail(clock_fail),
	.osc_drive_en(osc_drive_en), .current_source(current_source));

// ---- tb/system_clock_source_and_pll_bench.sv ----
// self-checking testbench of the system clock controller
`timescale 1ns/100ps
module system_clock_source_and_pll_bench
	import clk_sys_pkg::*;
;
	logic		pclk, presetn, psel, penable, pwrite, pri_en, config_programmed;
	logic [11:0]	paddr;
	logic [31:0]	pwdata, prdata;
	logic		pready, pslverr, fast_rc_osc, primary_osc_pin, secondary_osc, low_power_rc_osc;
	logic [2:0]	initial_source_sel, current_source;
	logic [1:0]	primary_osc_kind;
	logic		instr_clk, fosc_pulse, low_power_rc_osc_ref_pulse, clock_fail, osc_drive_en;
	logic [32:0]	e, m, q_exp[$], q_mask[$];
	int		num_errors = 0, check_count = 0, cycles = 0, n_fosc = 0, n_instr = 0, k;
	int		mt[8] = '{0, 1, 2, 5, 8, 9, 10, 11};

	clk_sys_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .fast_rc_osc, .primary_osc_pin, .secondary_osc, .low_power_rc_osc, .initial_source_sel,
		.primary_osc_kind, .config_programmed, .instr_clk, .fosc_pulse, .low_power_rc_osc_ref_pulse, .clock_fail,
		.osc_drive_en, .current_source);
	osc_model u_osc (.pri_en, .fast_rc_osc, .primary_osc_pin, .secondary_osc, .low_power_rc_osc);

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge instr_clk) n_instr++;
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (fosc_pulse === 1'b1) n_fosc <= n_fosc + 1;
		if (cycles == 90000) begin
			num_errors++;
			end_of_test();
		end
	end
	// read results are taken off the queue in the order they were asked for
	always @(posedge pclk) if (psel && penable && !pwrite && pready === 1'b1) begin
		e = q_exp.pop_front();
		m = q_mask.pop_front();
		check_count++;
		if ((({pslverr, prdata} ^ e) & m) !== 33'h0) begin
			num_errors++;
			$display("MISMATCH read %h expected %h seen %h", paddr, e, {pslverr, prdata});
		end
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic end_of_test;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] g);
		check_count++;
		if (g !== ex) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, ex, g);
		end
	endtask
	task automatic near(input string n, input int ex, input int g);
		check_count++;
		if (g > ex + 2 || g < ex - 2) begin
			num_errors++;
			$display("MISMATCH %s expected %0d seen %0d", n, ex, g);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] ex, input logic [32:0] mk);
		q_exp.push_back(ex);
		q_mask.push_back(mk);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic restart(input logic [2:0] s, input logic [1:0] kd, input logic prog);
		presetn <= 1'b0;
		initial_source_sel <= s;
		primary_osc_kind <= kd;
		config_programmed <= prog;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (12) @(posedge pclk);
	endtask
	task automatic measure(input int num, input int den);
		int f0 = n_fosc;
		int i0 = n_instr;
		repeat (512) @(posedge fast_rc_osc);
		near("fosc", 512 * num / den, n_fosc - f0);
		near("instr", 256 * num / den, n_instr - i0);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{presetn, initial_source_sel, primary_osc_kind, config_programmed} = '0;
		pri_en = 1'b1;
		void'($urandom(32'hf7ca));
		restart(3'b011, 2'b01, 1'b0);
		chk("source", 32'h0, {29'h0, current_source});
		rd(OSC_CONTROL_OFF, 33'h0, 33'h7000);
		rd(CLOCK_DIVISOR_OFF, 33'h40, '1);
		rd(PLL_FEEDBACK_OFF, 33'h30, '1);
		rd(12'h00c, {1'b1, 32'h0}, '1);
		repeat (4) begin
			k = $urandom;
			apb(1'b1, CLOCK_DIVISOR_OFF, 32'(k));
			rd(CLOCK_DIVISOR_OFF, {1'b0, 32'(k) & 32'h7df}, '1);
			apb(1'b1, PLL_FEEDBACK_OFF, ~32'(k));
			apb(1'b1, 12'h00c, 32'(k));
			rd(PLL_FEEDBACK_OFF, {1'b0, ~32'(k) & 32'h1ff}, '1);
		end
		for (int s = 0; s < 8; s++) begin
			k = $urandom_range(2, 0);
			restart(3'(s), 2'(k), 1'b1);
			e = {13'h0, 4'(mt[s] + ((s == 2 || s == 3) ? k : 0)), 1'b0, 3'(s), 1'b0, 3'(s), 8'h0};
			rd(OSC_CONTROL_OFF, e, 33'hf7700);
			chk("drive", {31'h0, (s == 2 || s == 3) && k != 0}, {31'h0, osc_drive_en});
		end
		restart(3'b111, 2'b00, 1'b1);
		for (int c = 0; c < 8; c++) begin
			apb(1'b1, CLOCK_DIVISOR_OFF, 32'(c) << 8);
			repeat (1100) @(posedge pclk);
			measure(1, (c == 7) ? 256 : (1 << c));
		end
		restart(3'b110, 2'b00, 1'b1);
		measure(1, 16);
		// fast rc taken as 12.5 MHz: settings keep vco in and out and fosc in range
		restart(3'b001, 2'b00, 1'b1);
		apb(1'b1, CLOCK_DIVISOR_OFF, 32'h00c0);
		apb(1'b1, PLL_FEEDBACK_OFF, 32'h1e);
		repeat (1100) @(posedge pclk);
		measure(2, 1);
		apb(1'b1, CLOCK_DIVISOR_OFF, 32'h0042);
		apb(1'b1, PLL_FEEDBACK_OFF, 32'h3e);
		repeat (1100) @(posedge pclk);
		measure(4, 1);
		restart(3'b010, 2'b00, 1'b1);
		repeat (600) @(posedge pclk);
		chk("fail", 32'h0, {31'h0, clock_fail});
		pri_en <= 1'b0;
		repeat (1000) @(posedge pclk);
		chk("fail", 32'h1, {31'h0, clock_fail});
		rd(OSC_CONTROL_OFF, 33'h8, 33'h7008);
		apb(1'b1, OSC_CONTROL_OFF, 32'h8);
		rd(OSC_CONTROL_OFF, 33'h0, 33'h8);
		pri_en <= 1'b1;
		end_of_test();
	end
endmodule
